// >>> pkg/msd_map.svh
// Offsets, field positions, reset values and window constants of the module-select driver
`ifndef MSD_MAP_SVH
`define MSD_MAP_SVH
`define MSD_WIN_BASE 16'hC000
`define MSD_WIN_STRIDE 16'h0040
`define MSD_WIN_BITS 6
`define MSD_REG_OFFSET 6'h08
`define MSD_EN_BIT 13
`define MSD_LVL_MSB 12
`define MSD_LINES 13
`define MSD_DYN_LA 8'hFF
`define MSD_LVL_RESET 13'h1FFF
`endif

// >>> pkg/msd_pkg.sv
// Types of the module-select driver
package msd_pkg;
	typedef struct packed {
		logic strobe;
		logic write;
		logic [15:0] addr;
		logic [15:0] wdata;
	} msd_bus_req_t;
	typedef struct packed {
		logic ack;
		logic [15:0] rdata;
	} msd_bus_rsp_t;
	typedef enum logic [1:0] {
		MSD_LA_STATIC,
		MSD_LA_WAIT,
		MSD_LA_ASSIGNED
	} msd_la_state_t;
endpackage : msd_pkg

// >>> design/msd_addr_decode.sv
// A16 window decode for the module-select driver
`timescale 1ns/10ps
`include "msd_map.svh"
module msd_addr_decode
	import msd_pkg::*;
(
	// Address in
	input wire logic [15:0] addr,
	input wire logic [7:0] logical_addr_value,
	// Decode out
	output logic in_window,
	output logic [5:0] offset
);
	logic [15:0] base;

	always_comb
	begin
		base = 16'(`MSD_WIN_BASE + {2'h0, logical_addr_value, 6'h00});
		in_window = (addr[15:`MSD_WIN_BITS] == base[15:`MSD_WIN_BITS]);
		offset = addr[`MSD_WIN_BITS-1:0];
	end
endmodule : msd_addr_decode

// >>> design/msd_module_select_driver.sv
// Slot-0 module-select line driver with A16 readback register
// Summary of operation
// - Writing one to bit 13 enables drivers
// - Writing zero disables all select drivers
// - Reset clears driver enable bit
// - Enable bit reads back driver state
// - Level bits 12:0 set driven line levels
// - Level writes apply only when bit 13 is written as one
// - Level bits read sampled line levels
// - A16 slave at C000 plus address times 40
// - Register decoded at window offset 08
// - Address static, or 255 means assigned
`timescale 1ns/10ps
`include "msd_map.svh"
module msd_module_select_driver
	import msd_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Static logical address strap
	input wire logic [7:0] static_logical_addr,
	// Dynamic assignment from the logical address register
	input wire logic la_write,
	input wire logic [7:0] la_wdata,
	// A16 slave access
	input wire msd_bus_req_t bus_req,
	output msd_bus_rsp_t bus_rsp,
	// Module-select lines
	input wire logic [12:0] module_select_lines_in,
	output logic [12:0] module_select_lines_out,
	output logic [12:0] module_select_lines_oe_n,
	// Current logical address
	output logic [7:0] logical_addr_value
);
	//--------------------------------------------------------------
	// State
	//--------------------------------------------------------------
	// Driver enable and driven levels
	logic en_q;
	logic en_d;
	logic [12:0] lvl_q;
	logic [12:0] lvl_d;
	// Logical address and its assignment phase
	logic [7:0] la_q;
	logic [7:0] la_d;
	msd_la_state_t la_st_q;
	msd_la_state_t la_st_d;
	// Registered bus response
	logic ack_q;
	logic ack_d;
	logic [15:0] rdata_q;
	logic [15:0] rdata_d;
	// Decode results
	logic in_window;
	logic [5:0] offset;
	logic wr_hit;
	logic rd_hit;

	//--------------------------------------------------------------
	// Decode helpers
	//--------------------------------------------------------------
	// Both byte lanes of the register select it
	function automatic logic reg_match(input logic [5:0] off);
		reg_match = (off[5:1] == 5'(`MSD_REG_OFFSET >> 1));
	endfunction : reg_match

	// Driver enable bit of a write data word
	function automatic logic enable_of(input logic [15:0] data);
		enable_of = data[`MSD_EN_BIT];
	endfunction : enable_of

	//--------------------------------------------------------------
	// Window decode
	//--------------------------------------------------------------
	msd_addr_decode u_dec
	(
		.addr(bus_req.addr),
		.logical_addr_value(la_q),
		.in_window(in_window),
		.offset(offset)
	);

	always_comb
	begin
		wr_hit = bus_req.strobe && bus_req.write && in_window && reg_match(offset);
		rd_hit = bus_req.strobe && !bus_req.write && in_window && reg_match(offset);
	end

	//--------------------------------------------------------------
	// Logical address
	//--------------------------------------------------------------
	// Strap is taken once, on the first clock after reset
	always_comb
	begin
		la_d = la_q;
		la_st_d = la_st_q;
		case (la_st_q)
			MSD_LA_STATIC:
			begin
				la_d = static_logical_addr;
				if (static_logical_addr == `MSD_DYN_LA)
				begin
					// Wait for the resource manager to assign one
					la_st_d = MSD_LA_WAIT;
				end
				else
				begin
					la_st_d = MSD_LA_ASSIGNED;
				end
			end
			MSD_LA_WAIT:
			begin
				if (la_write)
				begin
					la_d = la_wdata;
					la_st_d = MSD_LA_ASSIGNED;
				end
			end
			MSD_LA_ASSIGNED:
			begin
				// A later assignment still moves the window
				if (la_write)
				begin
					la_d = la_wdata;
				end
			end
			default:
			begin
				la_st_d = MSD_LA_STATIC;
			end
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			la_q <= 8'h00;
			la_st_q <= MSD_LA_STATIC;
		end
		else
		begin
			la_q <= la_d;
			la_st_q <= la_st_d;
		end
	end

	//--------------------------------------------------------------
	// Driver register
	//--------------------------------------------------------------
	always_comb
	begin
		en_d = en_q;
		lvl_d = lvl_q;
		if (wr_hit)
		begin
			en_d = enable_of(bus_req.wdata);
			// Levels written with the enable clear are dropped
			if (enable_of(bus_req.wdata))
			begin
				lvl_d = bus_req.wdata[`MSD_LVL_MSB:0];
			end
		end
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			en_q <= 1'b0;
			lvl_q <= `MSD_LVL_RESET;
		end
		else
		begin
			en_q <= en_d;
			lvl_q <= lvl_d;
		end
	end

	//--------------------------------------------------------------
	// Bus response
	//--------------------------------------------------------------
	always_comb
	begin
		ack_d = bus_req.strobe && in_window;
		rdata_d = 16'h0000;
		// Level bits show the live lines, not the written value
		if (rd_hit)
		begin
			rdata_d = {2'b00, en_q, module_select_lines_in};
		end
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			ack_q <= 1'b0;
			rdata_q <= 16'h0000;
		end
		else
		begin
			ack_q <= ack_d;
			rdata_q <= rdata_d;
		end
	end

	//--------------------------------------------------------------
	// Outputs
	//--------------------------------------------------------------
	always_comb
	begin
		bus_rsp.ack = ack_q;
		bus_rsp.rdata = rdata_q;
		logical_addr_value = la_q;
	end

	//--------------------------------------------------------------
	// Line drivers
	//--------------------------------------------------------------
	// One driver per line, all released together
	for (genvar gi = 0; gi < `MSD_LINES; gi++)
	begin : g_line
		assign module_select_lines_out[gi] = lvl_q[gi];
		assign module_select_lines_oe_n[gi] = ~en_q;
	end
endmodule : msd_module_select_driver

// >>> test/msd_module_select_driver_assertions.sv
// Checker of the module-select driver
`timescale 1ns/10ps
module msd_chk import msd_pkg::*; (input wire logic clk, reset,
	input wire msd_bus_req_t bus_req, input wire msd_bus_rsp_t bus_rsp,
	input wire logic [12:0] module_select_lines_in, module_select_lines_out,
	input wire logic [12:0] module_select_lines_oe_n, input wire logic [7:0] logical_addr_value);
	wire [15:0] d = bus_req.wdata, r = bus_rsp.rdata;
	wire [12:0] o = module_select_lines_oe_n, q = module_select_lines_out;
	wire s = bus_req.strobe & bus_req.addr[15:6] == 10'h300 + logical_addr_value;
	wire h = s & bus_req.addr[5:1] == 5'h04, w = bus_req.write, k = bus_rsp.ack;
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	AST_ACK: assert property (s |=> k) else $error("no ack");
	AST_IDLE: assert property (!s |=> !k) else $error("stray ack");
	AST_EN: assert property (h && w |=> o == {13{!$past(d[13])}}) else $error("enable");
	AST_LVL: assert property (h && w && d[13] |=> q == $past(d[12:0])) else $error("level");
	AST_HOLD: assert property (h && w && !d[13] |=> $stable(q)) else $error("hold");
	AST_RD: assert property (h && !w |=> r == {2'b00, !$past(o[0]),
		$past(module_select_lines_in)}) else $error("read");
	AST_OFF: assert property (s && !h && !w |=> r == 0) else $error("offset");
	AST_RST: assert property ($past(reset) |-> &o) else $error("reset");
	cover property (h && w && d[13]);
	cover property (h && !w);
	cover property (s && !h);
endmodule : msd_chk
bind msd_module_select_driver msd_chk i_chk (.*);

// >>> test/msd_lines.sv
// Other slots on the module-select lines
`timescale 1ns/10ps
module msd_lines (input wire logic [12:0] drv, oe_n, output logic [12:0] lvl);
	assign lvl = drv & ~oe_n | 13'h0A5A & oe_n;
endmodule : msd_lines

// >>> test/msd_module_select_driver_tb.sv
// Testbench of the module-select driver
`timescale 1ns/10ps
module msd_module_select_driver_tb import msd_pkg::*;;
	logic clk = 0, reset = 1, la_write = 0;
	logic [7:0] strap = 8'h05, la_data = 8'h22, la_val;
	logic [12:0] li, lo, oe;
	msd_bus_req_t req = '0;
	msd_bus_rsp_t rsp;
	int error_cnt = 0, checked = 0;
	always #20 clk = ~clk;
	msd_module_select_driver i_dut (.clk, .reset, .static_logical_addr(strap), .la_write,
		.la_wdata(la_data), .bus_req(req), .bus_rsp(rsp), .module_select_lines_in(li),
		.module_select_lines_out(lo), .module_select_lines_oe_n(oe),
		.logical_addr_value(la_val));
	msd_lines i_far (.drv(lo), .oe_n(oe), .lvl(li));
	task chk(logic [31:0] g, e);
		checked++;
		error_cnt += int'(g !== e);
		if (g !== e)
			$display("CHECK FAILED %0t got %h", $time, g);
	endtask : chk
	task acc(logic w, logic [15:0] a, d = '0);
		@(posedge clk);
		#1 {la_write, req} = {1'b0, 1'b1, w, a, d};
		@(posedge clk);
		#1 req = '0;
	endtask : acc
	task t_reset;
		acc(0, 16'hC148);
		chk({oe, rsp}, {13'h1FFF, 17'h1_0A5A});
		chk(la_val, 8'h05);
	endtask : t_reset
	task t_drive;
		acc(1, 16'hC148, 16'hF234);
		acc(0, 16'hC149);
		chk({oe, rsp}, {13'h0000, 17'h1_3234});
		acc(1, 16'hC148, 16'h0FFF);
		chk({oe, lo}, {13'h1FFF, 13'h1234});
		acc(1, 16'hC149, 16'h2001);
		chk(lo, 13'h0001);
	endtask : t_drive
	task t_window;
		acc(1, 16'hC17E, 16'hFFFF);
		chk({rsp, lo}, {17'h1_0000, 13'h0001});
		acc(0, 16'hC17E);
		chk(rsp, 17'h1_0000);
		acc(0, 16'hC100);
		chk(rsp.ack, 0);
		la_write = 1;
		acc(0, 16'hC888);
		chk({rsp.ack, la_val}, {1'b1, 8'h22});
	endtask : t_window
	task t_dynamic;
		@(posedge clk);
		#1 {reset, strap, la_data} = {1'b1, 8'hFF, 8'h3C};
		repeat (2) @(posedge clk);
		#1 reset = 0;
		repeat (3) @(posedge clk);
		#1 chk({oe, la_val}, {13'h1FFF, 8'hFF});
		acc(0, 16'hFFC8);
		chk(rsp, 17'h1_0A5A);
		la_write = 1;
		acc(1, 16'hCF08, 16'h2ABC);
		chk({rsp.ack, oe, lo}, {1'b1, 13'h0000, 13'h0ABC});
		chk(la_val, 8'h3C);
	endtask : t_dynamic
	task test_done(int x);
		error_cnt += x;
		$display("errors %0d checks %0d", error_cnt, checked);
		if (error_cnt == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : test_done
	initial
	begin
		repeat (10) @(posedge clk);
		#1 reset = 0;
		repeat (2) @(posedge clk);
		t_reset;
		t_drive;
		t_window;
		t_dynamic;
		test_done(0);
	end
	initial #9000 test_done(1);
endmodule : msd_module_select_driver_tb
